/* hdl/cpu_addr_consts.svh */
// Constants for the processor reset start-up and address generator.
// Assumes inclusion by bare name from the design file only.
`ifndef CPU_ADDR_CONSTS_SVH
`define CPU_ADDR_CONSTS_SVH

`define CAG_OSC_KHZ        3580
`define CAG_PROC_KHZ       1190
`define CAG_CLK_DIV        3
`define CAG_ADDR_BITS      13
`define CAG_RESET_CYCLES   6
`define CAG_VEC_LO         16'hFFFC
`define CAG_VEC_HI         16'hFFFD
`define CAG_ZERO_PAGE      8'h00
`define CAG_PC_RESET       16'h0000

`endif

/* hdl/cpu_addr_pkg.sv */
// Types for the processor reset start-up and address generator.
// Assumes the constants header defines every numeric value used here.
package cpu_addr_pkg;

  typedef enum logic [3:0] {
    M_ACC,
    M_IMM,
    M_ABS,
    M_ZP,
    M_ZPX,
    M_ZPY,
    M_ABSX,
    M_ABSY,
    M_IMP,
    M_REL,
    M_INDX,
    M_INDY,
    M_IND
  } mode_t;

  typedef enum logic [2:0] {
    S_HOLD,
    S_WAIT,
    S_VEC_LO,
    S_VEC_HI,
    S_IDLE,
    S_RD_LO,
    S_RD_HI
  } fsm_t;

  typedef struct packed {
    mode_t       mode;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  x;
    logic [7:0]  y;
    logic [15:0] pc_next;
  } req_t;

  typedef struct packed {
    logic [15:0] ea;
    logic [7:0]  operand;
    logic        has_ea;
    logic        has_operand;
    logic        pc_load;
  } result_t;

  typedef struct packed {
    fsm_t        fsm;
    logic [1:0]  div;
    logic [2:0]  wcnt;
    logic        por_q;
    logic [15:0] pc;
    logic        imask;
    logic [15:0] ptr;
    logic [7:0]  tmp_lo;
    mode_t       mode;
    logic [7:0]  yidx;
    logic        done;
    result_t     res;
  } state_t;

endpackage

/* hdl/cpu_reset_and_address_gen.sv */
// Processor reset start-up, processor-cycle divider and effective-address unit.
// Assumes synchronous inputs, memory that answers a read within the same
// processor cycle, and a reset pin held low long enough at power-up.
//
// Notes on behaviour
// - Processor cycle is clock divided by three
// - Thirteen address bits reach the memory bus
// - Reset sequence starts on reset pin rising
// - After six cycles: mask set, vector fetched
// - Accumulator mode: one byte, no memory operand
// - Immediate mode: second byte is the operand
// - Absolute: second byte low, third byte high
// - Zero page: high address byte forced zero
// - Zero page indexed wraps inside page zero
// - Indexed absolute adds index to base
// - Implied mode fetches no address bytes
// - Branch target is next pc plus offset
// - Indexed indirect reads pointer at base plus X
// - Indexed indirect pointer bytes stay in page zero
// - Indirect indexed adds Y, carry into high
// - Absolute indirect loads pc through pointer
// - Ready low halts every state but hold until ready returns high
`include "cpu_addr_consts.svh"

module cpu_reset_and_address_gen #(
  parameter int ADDR_W       = `CAG_ADDR_BITS,
  parameter int CLK_DIV      = `CAG_CLK_DIV,
  parameter int RESET_CYCLES = `CAG_RESET_CYCLES
) (
  input  wire logic                  i_clk,              // Oscillator-rate clock
  input  wire logic                  i_rst,              // Synchronous reset, high
  input  wire logic                  i_power_on_clear_n, // Reset pin, low active
  input  wire logic                  i_rdy,              // Internal ready, low halts
  input  wire logic                  i_req_valid,        // Address request offered
  input  wire cpu_addr_pkg::req_t    i_req,              // Request contents
  output logic                       o_req_ready,        // Request taken this cycle
  output logic                       o_done,             // Result valid pulse
  output cpu_addr_pkg::result_t      o_result,           // Computed result
  output logic [ADDR_W-1:0]          o_addr,             // Memory address
  output logic                       o_rd,               // Memory read strobe
  input  wire logic [7:0]            i_data,             // Memory read data
  output logic                       o_phi_en,           // Processor cycle pulse
  output logic [15:0]                o_pc,               // Program counter
  output logic                       o_irq_mask,         // Interrupt mask flag
  output logic                       o_running           // Start-up complete
);

  if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr_w
    $error("ADDR_W must be 1 to 16");
  end
  if (CLK_DIV < 2 || CLK_DIV > 4) begin : g_bad_clk_div
    $error("CLK_DIV must be 2 to 4");
  end
  if (RESET_CYCLES < 1 || RESET_CYCLES > 8) begin : g_bad_reset_cycles
    $error("RESET_CYCLES must be 1 to 8");
  end

  localparam logic [1:0] DIV_TOP  = 2'(CLK_DIV - 1);
  localparam logic [2:0] WAIT_TOP = 3'(RESET_CYCLES - 1);

  function automatic logic [15:0] zero_page(input logic [7:0] lo);
    zero_page = {`CAG_ZERO_PAGE, lo};
  endfunction

  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction

  cpu_addr_pkg::state_t st;
  cpu_addr_pkg::state_t next_st;

  logic phi_en;
  logic step;
  logic accept;

  assign phi_en = (st.div == DIV_TOP);
  assign step   = phi_en && i_rdy;
  assign accept = o_req_ready && i_req_valid;

  always_comb begin
    logic [7:0] zsum;
    logic [8:0] lsum;
    zsum    = 8'h00;
    lsum    = 9'h000;
    next_st = st;
    next_st.done  = 1'b0;
    next_st.por_q = i_power_on_clear_n;
    next_st.div   = (st.div == DIV_TOP) ? 2'h0 : st.div + 2'h1;
    if (!i_power_on_clear_n) begin
      next_st.fsm  = cpu_addr_pkg::S_HOLD;
      next_st.wcnt = 3'h0;
    end else begin
      case (st.fsm)
        cpu_addr_pkg::S_HOLD: begin
          if (!st.por_q) begin
            next_st.fsm  = cpu_addr_pkg::S_WAIT;
            next_st.wcnt = 3'h0;
          end
        end
        cpu_addr_pkg::S_WAIT: begin
          if (step) begin
            if (st.wcnt == WAIT_TOP) begin
              next_st.fsm   = cpu_addr_pkg::S_VEC_LO;
              next_st.imask = 1'b1;
              next_st.ptr   = `CAG_VEC_LO;
            end else begin
              next_st.wcnt = st.wcnt + 3'h1;
            end
          end
        end
        cpu_addr_pkg::S_VEC_LO: begin
          if (step) begin
            next_st.tmp_lo = i_data;
            next_st.ptr    = `CAG_VEC_HI;
            next_st.fsm    = cpu_addr_pkg::S_VEC_HI;
          end
        end
        cpu_addr_pkg::S_VEC_HI: begin
          if (step) begin
            next_st.pc  = {i_data, st.tmp_lo};
            next_st.fsm = cpu_addr_pkg::S_IDLE;
          end
        end
        cpu_addr_pkg::S_IDLE: begin
          if (accept) begin
            next_st.mode = i_req.mode;
            next_st.yidx = i_req.y;
            next_st.res  = '0;
            next_st.done = 1'b1;
            case (i_req.mode)
              cpu_addr_pkg::M_ACC, cpu_addr_pkg::M_IMP: begin
                next_st.res.has_ea = 1'b0;
              end
              cpu_addr_pkg::M_IMM: begin
                next_st.res.operand     = i_req.b1;
                next_st.res.has_operand = 1'b1;
              end
              cpu_addr_pkg::M_ABS: begin
                next_st.res.ea     = {i_req.b2, i_req.b1};
                next_st.res.has_ea = 1'b1;
              end
              cpu_addr_pkg::M_ZP: begin
                next_st.res.ea     = zero_page(i_req.b1);
                next_st.res.has_ea = 1'b1;
              end
              cpu_addr_pkg::M_ZPX, cpu_addr_pkg::M_ZPY: begin
                zsum = (i_req.mode == cpu_addr_pkg::M_ZPX) ? i_req.b1 + i_req.x
                                                           : i_req.b1 + i_req.y;
                next_st.res.ea     = zero_page(zsum);
                next_st.res.has_ea = 1'b1;
              end
              cpu_addr_pkg::M_ABSX: begin
                next_st.res.ea     = {i_req.b2, i_req.b1} + {8'h00, i_req.x};
                next_st.res.has_ea = 1'b1;
              end
              cpu_addr_pkg::M_ABSY: begin
                next_st.res.ea     = {i_req.b2, i_req.b1} + {8'h00, i_req.y};
                next_st.res.has_ea = 1'b1;
              end
              cpu_addr_pkg::M_REL: begin
                next_st.res.ea      = i_req.pc_next + sext8(i_req.b1);
                next_st.res.has_ea  = 1'b1;
                next_st.res.pc_load = 1'b1;
                next_st.pc          = i_req.pc_next + sext8(i_req.b1);
              end
              cpu_addr_pkg::M_INDX: begin
                zsum         = i_req.b1 + i_req.x;
                next_st.ptr  = zero_page(zsum);
                next_st.fsm  = cpu_addr_pkg::S_RD_LO;
                next_st.done = 1'b0;
              end
              cpu_addr_pkg::M_INDY: begin
                next_st.ptr  = zero_page(i_req.b1);
                next_st.fsm  = cpu_addr_pkg::S_RD_LO;
                next_st.done = 1'b0;
              end
              cpu_addr_pkg::M_IND: begin
                next_st.ptr  = {i_req.b2, i_req.b1};
                next_st.fsm  = cpu_addr_pkg::S_RD_LO;
                next_st.done = 1'b0;
              end
              default: begin
                next_st.res.has_ea = 1'b0;
              end
            endcase
          end
        end
        cpu_addr_pkg::S_RD_LO: begin
          if (step) begin
            next_st.tmp_lo = i_data;
            next_st.fsm    = cpu_addr_pkg::S_RD_HI;
            if (st.mode == cpu_addr_pkg::M_IND) begin
              next_st.ptr = st.ptr + 16'h0001;
            end else begin
              next_st.ptr = zero_page(st.ptr[7:0] + 8'h01);
            end
          end
        end
        cpu_addr_pkg::S_RD_HI: begin
          if (step) begin
            next_st.fsm        = cpu_addr_pkg::S_IDLE;
            next_st.done       = 1'b1;
            next_st.res.has_ea = 1'b1;
            if (st.mode == cpu_addr_pkg::M_INDY) begin
              lsum           = {1'b0, st.tmp_lo} + {1'b0, st.yidx};
              next_st.res.ea = {i_data + {7'h00, lsum[8]}, lsum[7:0]};
            end else begin
              next_st.res.ea = {i_data, st.tmp_lo};
            end
            if (st.mode == cpu_addr_pkg::M_IND) begin
              next_st.res.pc_load = 1'b1;
              next_st.pc          = {i_data, st.tmp_lo};
            end
          end
        end
        default: begin
          next_st.fsm = cpu_addr_pkg::S_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st       <= '0;
      st.fsm   <= cpu_addr_pkg::S_HOLD;
      st.por_q <= 1'b1;
      st.pc    <= `CAG_PC_RESET;
      st.mode  <= cpu_addr_pkg::M_IMP;
    end else begin
      st <= next_st;
    end
  end

  assign o_rd        = (st.fsm == cpu_addr_pkg::S_VEC_LO) || (st.fsm == cpu_addr_pkg::S_VEC_HI)
                    || (st.fsm == cpu_addr_pkg::S_RD_LO) || (st.fsm == cpu_addr_pkg::S_RD_HI);
  assign o_addr      = st.ptr[ADDR_W-1:0];
  // A request is never signalled taken while the reset pin discards it
  assign o_req_ready = (st.fsm == cpu_addr_pkg::S_IDLE) && step && i_power_on_clear_n;
  assign o_done      = st.done;
  assign o_result    = st.res;
  assign o_phi_en    = phi_en;
  assign o_pc        = st.pc;
  assign o_irq_mask  = st.imask;
  assign o_running   = (st.fsm == cpu_addr_pkg::S_IDLE) || (st.fsm == cpu_addr_pkg::S_RD_LO)
                    || (st.fsm == cpu_addr_pkg::S_RD_HI);

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  logic [3:0] en_seen;
  always_ff @(posedge i_clk) begin
    if (i_rst || st.fsm != cpu_addr_pkg::S_WAIT) begin
      en_seen <= 4'h0;
    end else if (step) begin
      en_seen <= en_seen + 4'h1;
    end
  end

  sequence s_accept_mode(cpu_addr_pkg::mode_t m);
    accept && i_req.mode == m;
  endsequence

  sequence s_ptr_reads;
    st.fsm == cpu_addr_pkg::S_RD_LO && step ##1 st.fsm == cpu_addr_pkg::S_RD_HI
    ##[0:300] (st.fsm == cpu_addr_pkg::S_RD_HI && step && i_power_on_clear_n);
  endsequence

  sequence s_ptr_last(cpu_addr_pkg::mode_t m);
    st.fsm == cpu_addr_pkg::S_RD_HI && step && i_power_on_clear_n && st.mode == m;
  endsequence

  a_divider_period: assert property (phi_en |=> !phi_en ##1 !phi_en ##1 phi_en)
    else $error("processor cycle pulse not every third clock");

  a_addr_bus_width: assert property (st.fsm == cpu_addr_pkg::S_VEC_LO
    |-> o_rd && o_addr == ADDR_W'(`CAG_VEC_LO))
    else $error("address bus does not carry vector low bits");

  a_reset_edge: assert property (
    st.fsm == cpu_addr_pkg::S_HOLD && !st.por_q && i_power_on_clear_n
    |=> st.fsm == cpu_addr_pkg::S_WAIT)
    else $error("rising reset edge did not start sequence");

  a_reset_six_cycles: assert property (
    st.fsm == cpu_addr_pkg::S_WAIT && $past(st.fsm) == cpu_addr_pkg::S_WAIT
    ##1 st.fsm == cpu_addr_pkg::S_VEC_LO |-> en_seen == 4'(RESET_CYCLES) && st.imask)
    else $error("vector fetch not six cycles after reset");

  a_vector_fetch: assert property (
    st.fsm == cpu_addr_pkg::S_VEC_HI && step && i_power_on_clear_n
    |=> o_pc == {$past(i_data), st.tmp_lo} && o_addr == ADDR_W'(`CAG_VEC_HI))
    else $error("program counter not loaded from vector");

  a_zp_wrap: assert property (s_accept_mode(cpu_addr_pkg::M_ZPX)
    |=> o_done && o_result.ea == {8'h00, 8'($past(i_req.b1) + $past(i_req.x))})
    else $error("zero page indexed address left page zero");

  a_imm_operand: assert property (s_accept_mode(cpu_addr_pkg::M_IMM)
    |=> o_done && !o_result.has_ea && o_result.operand == $past(i_req.b1))
    else $error("immediate operand wrong");

  a_branch_target: assert property (s_accept_mode(cpu_addr_pkg::M_REL)
    |=> o_result.ea == $past(i_req.pc_next) + {{8{$past(i_req.b1[7])}}, $past(i_req.b1)})
    else $error("branch target wrong");

  a_indx_page_zero: assert property (
    (st.fsm == cpu_addr_pkg::S_RD_LO || st.fsm == cpu_addr_pkg::S_RD_HI)
    && st.mode == cpu_addr_pkg::M_INDX |-> st.ptr[15:8] == 8'h00)
    else $error("indexed indirect pointer left page zero");

  a_ready_halt: assert property (
    !i_rdy && st.fsm != cpu_addr_pkg::S_HOLD && i_power_on_clear_n
    |=> st.fsm == $past(st.fsm) && !o_done)
    else $error("state advanced while ready low");

  a_indirect_done: assert property (s_ptr_reads |=> o_done && o_result.has_ea)
    else $error("pointer reads did not finish with result");

  a_acc_no_memory: assert property (s_accept_mode(cpu_addr_pkg::M_ACC)
    |=> o_done && !o_result.has_ea && !o_result.has_operand && !o_rd)
    else $error("accumulator mode produced a memory operand");

  a_implied_no_fetch: assert property (s_accept_mode(cpu_addr_pkg::M_IMP)
    |=> o_done && !o_result.has_ea && !o_result.has_operand && !o_rd)
    else $error("implied mode fetched address bytes");

  a_abs_address: assert property (s_accept_mode(cpu_addr_pkg::M_ABS)
    |=> o_result.has_ea && o_result.ea == {$past(i_req.b2), $past(i_req.b1)})
    else $error("absolute address bytes misplaced");

  a_zp_high_zero: assert property (s_accept_mode(cpu_addr_pkg::M_ZP)
    |=> o_result.has_ea && o_result.ea == {8'h00, $past(i_req.b1)})
    else $error("zero page high byte not zero");

  a_abs_indexed: assert property (s_accept_mode(cpu_addr_pkg::M_ABSY)
    |=> o_result.ea == {$past(i_req.b2), $past(i_req.b1)} + {8'h00, $past(i_req.y)})
    else $error("indexed absolute address wrong");

  a_indy_carry: assert property (s_ptr_last(cpu_addr_pkg::M_INDY)
    |=> o_result.ea == {$past(i_data), $past(st.tmp_lo)} + {8'h00, $past(st.yidx)})
    else $error("indirect indexed carry not added to high byte");

  a_ind_pc_load: assert property (s_ptr_last(cpu_addr_pkg::M_IND)
    |=> o_result.pc_load && o_pc == {$past(i_data), $past(st.tmp_lo)})
    else $error("absolute indirect did not load program counter");

endmodule

/* bench/mem_model.sv */
// Program and data memory model on the far side of the address generator.
// Assumes a registered address and a level read strobe; answers in the same cycle.
module mem_model (
  input  wire logic        i_clk,  // Oscillator-rate clock
  input  wire logic [12:0] i_addr, // Read address
  input  wire logic        i_rd,   // Read strobe
  output logic [7:0]       o_data  // Read data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] last;

  function automatic logic [7:0] pat(input logic [12:0] a);
    return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h5A;
  endfunction

  // Unselected bus shows the inverse of the last byte, never a stale match
  always_comb o_data = i_rd ? pat(i_addr) : ~last;

  initial last = 8'h00;
  always @(posedge i_clk) begin
    if (i_rd) last <= pat(i_addr);
  end
endmodule

/* bench/tb.sv */
// Self-checking bench for the reset start-up and effective-address unit.
// Assumes mem_model as the memory and the default divider and address width.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int N_RST = 6;
  logic                  clk, rst, por_n, rdy, req_valid, req_ready, done, rd, phi_en;
  logic                  irq_mask, running;
  cpu_addr_pkg::req_t    req;
  cpu_addr_pkg::result_t result;
  logic [12:0]           addr;
  logic [7:0]            data;
  logic [15:0]           pc;
  logic [12:0]           rd_log[$];
  int                    miscompares, n_tests, cycles;

  cpu_reset_and_address_gen #(.RESET_CYCLES(N_RST)) i_dut (
    .i_clk(clk), .i_rst(rst), .i_power_on_clear_n(por_n), .i_rdy(rdy),
    .i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready), .o_done(done),
    .o_result(result), .o_addr(addr), .o_rd(rd), .i_data(data), .o_phi_en(phi_en),
    .o_pc(pc), .o_irq_mask(irq_mask), .o_running(running));

  mem_model i_mem (.i_clk(clk), .i_addr(addr), .i_rd(rd), .o_data(data));

  always #10 clk = ~clk;

  // Completed reads only: a halted read is not logged twice
  always @(posedge clk) begin
    if (rd === 1'b1 && phi_en === 1'b1 && rdy === 1'b1) rd_log.push_back(addr);
  end

  function automatic logic [7:0] pat(input logic [12:0] a);
    return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h5A;
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic issue(input cpu_addr_pkg::mode_t m, input logic [7:0] v1, v2, vx, vy,
                       input logic [15:0] pcn);
    int k;
    rd_log.delete();
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{m, v1, v2, vx, vy, pcn};
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (req_ready !== 1'b1 && k < 20);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask

  task automatic wait_done(input int lim);
    int k;
    k = 0;
    while (done !== 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk("done", 16'h0001, {15'h0000, done});
  endtask

  // An expected has_ea or has_operand flag of x is left unchecked; pc_load is always checked
  task automatic chk_res(input logic he, ho, pl, input logic [15:0] ea, input logic [7:0] op);
    if (he !== 1'bx) chk("has_ea", {15'h0000, he}, {15'h0000, result.has_ea});
    if (ho !== 1'bx) chk("has_operand", {15'h0000, ho}, {15'h0000, result.has_operand});
    chk("pc_load", {15'h0000, pl}, {15'h0000, result.pc_load});
    if (he === 1'b1) chk("ea", ea, result.ea);
    if (ho === 1'b1) chk("operand", {8'h00, op}, {8'h00, result.operand});
    if (pl === 1'b1) begin
      @(negedge clk);
      chk("pc", ea, pc);
    end
  endtask

  // Direct modes answer one clock after the request is taken
  task automatic dir(input cpu_addr_pkg::mode_t m, input logic [7:0] v1, v2,
                     input logic [15:0] pcn, input logic he, ho, pl, input logic [15:0] ea);
    issue(m, v1, v2, 8'h20, 8'h11, pcn);
    wait_done(1);
    chk("no_read", 16'h0000, {15'h0000, rd});
    chk_res(he, ho, pl, ea, v1);
  endtask

  task automatic ind(input cpu_addr_pkg::mode_t m, input logic [7:0] v1, v2, vx, vy,
                     input logic [12:0] pa, pb, input logic pl, input int stall);
    logic [15:0] ea;
    logic        held;
    ea = {pat(pb), pat(pa)} + ((m == cpu_addr_pkg::M_INDY) ? {8'h00, vy} : 16'h0000);
    held = 1'b1;
    issue(m, v1, v2, vx, vy, 16'h0000);
    if (stall > 0) begin
      rdy <= 1'b0;
      repeat (stall) begin
        @(negedge clk);
        if (done === 1'b1 || req_ready === 1'b1) held = 1'b0;
      end
      chk("halted", 16'h0001, {15'h0000, held});
      @(posedge clk);
      rdy <= 1'b1;
    end
    wait_done((stall > 0) ? 8 : 7);
    chk("rd_idle", 16'h0000, {15'h0000, rd});
    chk("read_lo", {3'h0, pa}, {3'h0, rd_log[0]});
    chk("read_hi", {3'h0, pb}, {3'h0, rd_log[1]});
    chk_res(1'b1, 1'b0, pl, ea, 8'h00);
  endtask

  task automatic t_startup();
    int n;
    repeat (20) @(posedge clk);
    chk("idle_running", 16'h0000, {15'h0000, running});
    chk("idle_mask", 16'h0000, {15'h0000, irq_mask});
    por_n <= 1'b0;
    repeat (9) @(posedge clk);
    rd_log.delete();
    por_n <= 1'b1;
    @(negedge clk);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (irq_mask === 1'b1) break;
      if (phi_en === 1'b1) n++;
    end
    chk("start_steps", N_RST[15:0], n[15:0]);
    chk("vec_lo_addr", 16'h1FFC, {3'h0, addr});
    n = 0;
    while (running !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("vec_pc", {pat(13'h1FFD), pat(13'h1FFC)}, pc);
    chk("vec_hi_addr", 16'h1FFD, {3'h0, rd_log[1]});
  endtask

  task automatic t_clock();
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (phi_en !== 1'b1 && k < 8);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (phi_en !== 1'b1 && k < 8);
    chk("phi_period", 16'h0003, k[15:0]);
  endtask

  task automatic t_direct();
    dir(cpu_addr_pkg::M_ACC, 8'h00, 8'h00, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000);
    dir(cpu_addr_pkg::M_IMP, 8'h00, 8'h00, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000);
    dir(cpu_addr_pkg::M_IMM, 8'h3C, 8'h00, 16'h0000, 1'b0, 1'b1, 1'b0, 16'h0000);
    dir(cpu_addr_pkg::M_ABS, 8'h34, 8'h12, 16'h0000, 1'b1, 1'b0, 1'b0, 16'h1234);
    dir(cpu_addr_pkg::M_ZP, 8'h80, 8'hFF, 16'h0000, 1'b1, 1'b0, 1'b0, 16'h0080);
    dir(cpu_addr_pkg::M_ZPX, 8'hF0, 8'hFF, 16'h0000, 1'b1, 1'b0, 1'b0, 16'h0010);
    dir(cpu_addr_pkg::M_ZPY, 8'hF0, 8'hFF, 16'h0000, 1'b1, 1'b0, 1'b0, 16'h0001);
    dir(cpu_addr_pkg::M_ABSX, 8'hF0, 8'h12, 16'h0000, 1'b1, 1'b0, 1'b0, 16'h1310);
    dir(cpu_addr_pkg::M_ABSY, 8'hFF, 8'hFF, 16'h0000, 1'b1, 1'b0, 1'b0, 16'h0010);
    dir(cpu_addr_pkg::M_REL, 8'h80, 8'h00, 16'h1000, 1'b1, 1'b0, 1'b1, 16'h0F80);
    dir(cpu_addr_pkg::M_REL, 8'h7F, 8'h00, 16'h1FF0, 1'b1, 1'b0, 1'b1, 16'h206F);
  endtask

  task automatic t_indirect();
    ind(cpu_addr_pkg::M_INDX, 8'hF0, 8'h00, 8'h0F, 8'h00, 13'h00FF, 13'h0000, 1'b0, 0);
    ind(cpu_addr_pkg::M_INDY, 8'hFF, 8'h00, 8'h00, 8'hFF, 13'h00FF, 13'h0000, 1'b0, 0);
    ind(cpu_addr_pkg::M_IND, 8'hFF, 8'h12, 8'h00, 8'h00, 13'h12FF, 13'h1300, 1'b1, 0);
  endtask

  task automatic t_ready();
    ind(cpu_addr_pkg::M_INDX, 8'h10, 8'h00, 8'h02, 8'h00, 13'h0012, 13'h0013, 1'b0, 15);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    por_n = 1'b1;
    rdy = 1'b1;
    req_valid = 1'b0;
    req = '0;
    miscompares = 0;
    n_tests = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_startup();
    t_clock();
    t_direct();
    t_indirect();
    t_ready();
    conclude();
  end
endmodule
